// >>> timer_prescaler_comparator_ctl_bench.sv
/*
 self-checking bench for the timer front end over apb.
 assumes zero-wait apb answers and the pin model beside the design.
*/
`timescale 1ns/1ns
`default_nettype none
module timer_prescaler_comparator_ctl_bench;
    import tpc_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, q, prdata;
    logic go = 0, lvl = 0, seen_clr = 0, err, pready, pslverr, pin, cmp;
    logic oe, o, pwr, nref, pref, wake, tick, clr;
    logic [7:0] tcnt;
    logic [7:0] opt [4] = '{8'h00, 8'h01, 8'h02, 8'h08};
    int wt [4] = '{64, 128, 256, 32};
    int n_fail = 0, n_compared = 0;
    tpc_timer_ctl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_ext_clock_pin(pin), .cmp_raw(cmp), .cmp_out_pin_o(o),
        .cmp_out_pin_oe(oe), .cmp_power_on_o(pwr), .neg_ref_sel_o(nref),
        .pos_ref_sel_o(pref), .cmp_wake_en(wake), .wdt_tick(tick), .wdt_clear(clr),
        .timer_count_o(tcnt));
    tpc_pin_model u_pins (.pclk(pclk), .go(go), .lvl(lvl), .pin(pin), .cmp(cmp));
    initial begin
        forever #4 pclk = !pclk;
    end
    always @(posedge pclk) begin
        if (clr === 1'b1) begin
            seen_clr <= 1'b1;
        end
    end
    task automatic end_sim;
        if (n_fail == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
            n_fail++;
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 20) begin
            n_fail++;
            end_sim();
        end
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(q, exp);
    endtask : rd
    task automatic pins_chk(input logic [31:0] exp);
        repeat (4) @(posedge pclk);
        chk({26'h0, oe, o, pwr, nref, pref, wake}, exp);
    endtask : pins_chk
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(TPC_OFS_TIMER, 32'h0000_0000);
        rd(TPC_OFS_OPTION, 32'h0000_00FF);
        rd(TPC_OFS_CMP, 32'h0000_007F);
        rd(TPC_OFS_STAT, 32'h0000_0000);
        rd(8'h14, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, TPC_OFS_OPTION, {24'h0, opt[i]});
            apb(1'b1, TPC_OFS_TIMER, 32'h0000_0000);
            repeat (wt[i]) @(posedge pclk);
            apb(1'b0, TPC_OFS_TIMER, 32'h0000_0000);
            chk({31'h0, q[7:0] inside {[7:10]}}, 32'h0000_0001);
        end
        chk({31'h0, seen_clr}, 32'h0000_0000);
        apb(1'b1, TPC_OFS_CMD, 32'h0000_0001);
        repeat (3) @(posedge pclk);
        chk({31'h0, seen_clr}, 32'h0000_0001);
        for (int e = 0; e < 2; e++) begin
            apb(1'b1, TPC_OFS_OPTION, e ? 32'h0000_0038 : 32'h0000_0028);
            apb(1'b1, TPC_OFS_CMP, 32'h0000_0078);
            apb(1'b1, TPC_OFS_TIMER, 32'h0000_0000);
            go <= 1'b1;
            repeat (40) @(posedge pclk);
            go <= 1'b0;
            repeat (8) @(posedge pclk);
            rd(TPC_OFS_TIMER, 32'h0000_0005);
        end
        apb(1'b1, TPC_OFS_TIMER, 32'h0000_00FE);
        repeat (8) @(posedge pclk);
        go <= 1'b1;
        repeat (24) @(posedge pclk);
        go <= 1'b0;
        repeat (8) @(posedge pclk);
        rd(TPC_OFS_TIMER, 32'h0000_0001);
        chk({24'h0000_00, tcnt}, 32'h0000_0001);
        apb(1'b1, TPC_OFS_CMP, 32'h0000_00AE);
        pins_chk(32'h0000_002F);
        rd(TPC_OFS_CMP, 32'h0000_002E);
        lvl <= 1'b1;
        pins_chk(32'h0000_003F);
        rd(TPC_OFS_CMP, 32'h0000_00AE);
        apb(1'b1, TPC_OFS_CMP, 32'h0000_000E);
        pins_chk(32'h0000_002F);
        apb(1'b1, TPC_OFS_CMP, 32'h0000_0066);
        pins_chk(32'h0000_0000);
        apb(1'b1, TPC_OFS_CMD, 32'h0000_0001);
        apb(1'b1, TPC_OFS_OPTION, 32'h0000_0000);
        rd(TPC_OFS_OPTION, 32'h0000_0000);
        apb(1'b1, TPC_OFS_CMD, 32'h0000_0001);
        apb(1'b1, TPC_OFS_TIMER, 32'h0000_0000);
        apb(1'b1, TPC_OFS_OPTION, 32'h0000_002F);
        apb(1'b1, TPC_OFS_CMD, 32'h0000_0001);
        @(posedge pclk);
        chk({31'h0, tick}, 32'h0000_0000);
        apb(1'b1, TPC_OFS_OPTION, 32'h0000_002B);
        rd(TPC_OFS_OPTION, 32'h0000_002B);
        end_sim();
    end
endmodule : timer_prescaler_comparator_ctl_bench
`default_nettype wire

// >>> tpc_pin_model.sv
/*
 far side of the timer front end: external clock pin and comparator level.
 assumes the bench raises go for whole periods of eight pclk cycles.
*/
`timescale 1ns/1ns
`default_nettype none
module tpc_pin_model (
    // clock
    input wire logic pclk,
    // control
    input wire logic go,
    input wire logic lvl,
    // outputs
    output logic pin,
    output logic cmp
);
    logic [1:0] cnt_r;
    assign cmp = lvl;
    // four cycles high, four low: above two periods each way
    always_ff @(posedge pclk) begin
        if (!go) begin
            cnt_r <= 2'h0;
            pin <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 2'h1;
            if (cnt_r == 2'h3) begin
                pin <= !pin;
            end
        end
    end
endmodule : tpc_pin_model
`default_nettype wire

// >>> tpc_pkg.sv
/*
 timer front end package: register offsets, field positions, reset values, timing counts.
 assumes an apb slave with 32-bit data, one word per register.
*/
package tpc_pkg;
    localparam logic [7:0] TPC_OFS_TIMER = 8'h00;
    localparam logic [7:0] TPC_OFS_OPTION = 8'h04;
    localparam logic [7:0] TPC_OFS_CMP = 8'h08;
    localparam logic [7:0] TPC_OFS_CMD = 8'h0C;
    localparam logic [7:0] TPC_OFS_STAT = 8'h10;
    localparam int TPC_OPT_PS_LSB = 0;
    localparam int TPC_OPT_ASSIGN = 3;
    localparam int TPC_OPT_EDGE = 4;
    localparam int TPC_OPT_SRC = 5;
    localparam int TPC_CMP_RESULT = 7;
    localparam int TPC_CMP_DRIVE_N = 6;
    localparam int TPC_CMP_POL = 5;
    localparam int TPC_CMP_TSRC = 4;
    localparam int TPC_CMP_ON = 3;
    localparam int TPC_CMP_NREF = 2;
    localparam int TPC_CMP_PREF = 1;
    localparam int TPC_CMP_WAKE_DIS = 0;
    localparam int TPC_CMD_WDT_CLR = 0;
    localparam logic [7:0] TPC_OPTION_RST = 8'hFF;
    localparam logic [6:0] TPC_CMP_RST = 7'h7F;
    localparam logic [7:0] TPC_TIMER_RST = 8'h00;
    localparam logic [7:0] TPC_SCALER_RST = 8'h00;
    localparam int TPC_PHASES = 4;
    localparam int TPC_PHASE_TWO = 1;
    localparam int TPC_PHASE_FOUR = 3;
    localparam int TPC_TOSC_NS = 8;
    localparam int TPC_CLK_NS = 8;
    localparam int TPC_TOSC_CYC = (TPC_TOSC_NS + TPC_CLK_NS - 1) / TPC_CLK_NS;
    typedef enum logic [1:0] {TPC_SRC_INSTR, TPC_SRC_CMP, TPC_SRC_PIN} tpc_src_e;
endpackage : tpc_pkg

// >>> tpc_scaler.sv
/*
 shared 8-bit scaler counter with ratio tap select.
 assumes a synchronous count enable and clear from the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module tpc_scaler #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic count_en,
    input wire logic clear,
    input wire logic [2:0] ratio,
    // tap
    output logic tap
);
    import tpc_pkg::*;
    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] cnt_nxt;
    assign cnt_nxt = clear ? TPC_SCALER_RST : (count_en ? cnt_r + 1'b1 : cnt_r);
    // ratio n taps bit n: divide by 2^(n+1)
    assign tap = cnt_r[ratio];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= TPC_SCALER_RST;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule : tpc_scaler
`default_nettype wire

// >>> tpc_sync2.sv
/*
 two flip-flop synchroniser for one level.
 assumes the input may change at any time relative to pclk.
*/
`timescale 1ns/1ns
`default_nettype none
module tpc_sync2 (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // level
    input wire logic d,
    output logic q
);
    logic meta_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : tpc_sync2
`default_nettype wire

// >>> tpc_timer_ctl.sv
/*
 timer clock front end: source mux, shared scaler, phase sampling, timer count,
 comparator control register. assumes an apb master and external analog comparator.
*/
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
// How it works
// - sample scaler output on phases two, four
// - increment three to seven periods after edge
// - one scaler, timer or watchdog, never both
// - option low nibble: assign bit, ratio
// - timer write clears scaler when timer-assigned
// - watchdog clear clears scaler when watchdog-assigned
// - scaler hidden from software, reset zero
// - bit 7 read-only comparator result
// - bit 6 low drives result to pin
// - bit 5 polarity, one passes unchanged
// - bit 4 low selects comparator as source
// - bit 3 switches comparator on
// - bit 2 selects negative pin, bit 1 positive pin
// - bit 0 low enables comparator wake-up
// - comparator bits act only while on
// - source: instruction, pin, or comparator
// - edge select: zero rising, one falling
// - assign bit low gives scaler to timer
`timescale 1ns/1ns
`default_nettype none
module tpc_timer_ctl (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins and comparator
    input wire logic timer_ext_clock_pin,
    input wire logic cmp_raw,
    output logic cmp_out_pin_o,
    output logic cmp_out_pin_oe,
    // comparator analog control
    output logic cmp_power_on_o,
    output logic neg_ref_sel_o,
    output logic pos_ref_sel_o,
    output logic cmp_wake_en,
    // watchdog side and timer count
    output logic wdt_tick,
    output logic wdt_clear,
    output logic [7:0] timer_count_o
);
    import tpc_pkg::*;

    logic [7:0] timer_count_r;
    logic [7:0] option_r;
    logic [6:0] cmp_ctl_r;
    logic [1:0] phase_r;
    logic pin_s;
    logic cmp_s;
    logic samp_r;
    logic samp_prev_r;
    logic src_prev_r;

    tpc_sync2 u_sync_pin (
        .pclk(pclk),
        .presetn(presetn),
        .d(timer_ext_clock_pin),
        .q(pin_s)
    );
    tpc_sync2 u_sync_cmp (
        .pclk(pclk),
        .presetn(presetn),
        .d(cmp_raw),
        .q(cmp_s)
    );

    // apb decode
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire wr_timer = wr && (paddr == TPC_OFS_TIMER);
    wire wr_option = wr && (paddr == TPC_OFS_OPTION);
    wire wr_cmp = wr && (paddr == TPC_OFS_CMP);
    wire wr_cmd = wr && (paddr == TPC_OFS_CMD);
    wire mapped = (paddr == TPC_OFS_TIMER) || (paddr == TPC_OFS_OPTION)
        || (paddr == TPC_OFS_CMP) || (paddr == TPC_OFS_CMD) || (paddr == TPC_OFS_STAT);
    assign pready = 1'b1;
    assign pslverr = acc && !mapped;

    // option and comparator fields
    wire assign_wdt = option_r[TPC_OPT_ASSIGN];
    wire [2:0] ratio = option_r[TPC_OPT_PS_LSB +: 3];
    wire cmp_on = cmp_ctl_r[TPC_CMP_ON];
    wire drive_n = cmp_on ? cmp_ctl_r[TPC_CMP_DRIVE_N] : 1'b1;
    wire cmp_polarity = cmp_on ? cmp_ctl_r[TPC_CMP_POL] : 1'b1;
    wire tsrc = cmp_on ? cmp_ctl_r[TPC_CMP_TSRC] : 1'b1;
    wire cmp_result = cmp_on ? (cmp_polarity ? cmp_s : ~cmp_s) : 1'b0;

    // timer source mux
    tpc_src_e src_sel;
    assign src_sel = !option_r[TPC_OPT_SRC] ? TPC_SRC_INSTR
        : ((tsrc && !drive_n) ? TPC_SRC_CMP
        : (tsrc ? TPC_SRC_PIN : TPC_SRC_CMP));
    // with drive on and tsrc set, the result is taken directly, not through the pin
    wire ext_raw = (src_sel == TPC_SRC_PIN) ? pin_s : cmp_result;
    wire ext_edge_in = option_r[TPC_OPT_EDGE] ? ~ext_raw : ext_raw;
    wire ext_rise = ext_edge_in && !src_prev_r;
    wire phase_end = (phase_r == 2'(TPC_PHASES - 1));

    // shared scaler count source
    wire scaler_to_timer = !assign_wdt;
    wire scal_cnt_en = scaler_to_timer
        ? ((src_sel == TPC_SRC_INSTR) ? phase_end : ext_rise) : phase_end;
    wire scal_clr = (wr_timer && scaler_to_timer)
        || (wdt_clear && assign_wdt);
    logic scal_tap;
    tpc_scaler #(.WIDTH(8)) u_scaler (
        .pclk(pclk),
        .presetn(presetn),
        .count_en(scal_cnt_en),
        .clear(scal_clr),
        .ratio(ratio),
        .tap(scal_tap)
    );
    wire scal_out = scaler_to_timer ? scal_tap : ext_edge_in;
    wire sample_now = (phase_r == 2'(TPC_PHASE_TWO)) || (phase_r == 2'(TPC_PHASE_FOUR));
    wire inst_inc = scaler_to_timer ? 1'b0 : phase_end;
    wire pre_inst = (src_sel == TPC_SRC_INSTR);
    wire samp_rise = samp_r && !samp_prev_r;
    wire do_inc = pre_inst ? (scaler_to_timer ? samp_rise : inst_inc) : samp_rise;
    wire [7:0] timer_nxt = wr_timer ? pwdata[7:0]
        : (do_inc ? 8'(timer_count_r + 8'h01) : timer_count_r);

    assign wdt_clear = wr_cmd && pwdata[TPC_CMD_WDT_CLR];
    assign wdt_tick = assign_wdt ? scal_tap : phase_end;
    assign cmp_out_pin_o = cmp_result;
    assign cmp_out_pin_oe = cmp_on && !drive_n;
    assign cmp_power_on_o = cmp_on;
    assign neg_ref_sel_o = cmp_on && cmp_ctl_r[TPC_CMP_NREF];
    assign pos_ref_sel_o = cmp_on && cmp_ctl_r[TPC_CMP_PREF];
    assign cmp_wake_en = cmp_on && !cmp_ctl_r[TPC_CMP_WAKE_DIS];
    assign timer_count_o = timer_count_r;

    // read mux
    wire [31:0] rd_nxt = (paddr == TPC_OFS_TIMER) ? {24'h0000_00, timer_count_r}
        : (paddr == TPC_OFS_OPTION) ? {24'h0000_00, option_r}
        : (paddr == TPC_OFS_CMP) ? {24'h0000_00, cmp_result, cmp_ctl_r}
        : 32'h0000_0000;
    assign prdata = rd_nxt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_r <= 2'b00;
            samp_r <= 1'b0;
            samp_prev_r <= 1'b0;
            src_prev_r <= 1'b0;
        end else begin
            phase_r <= phase_r + 2'b01;
            src_prev_r <= ext_edge_in;
            // previous sample kept every cycle so a sampled rise lasts one cycle
            samp_prev_r <= samp_r;
            if (sample_now) begin
                samp_r <= scal_out;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_count_r <= TPC_TIMER_RST;
            option_r <= TPC_OPTION_RST;
            cmp_ctl_r <= TPC_CMP_RST;
        end else begin
            timer_count_r <= timer_nxt;
            if (wr_option) begin
                option_r <= pwdata[7:0];
            end
            if (wr_cmp) begin
                cmp_ctl_r <= pwdata[6:0];
            end
        end
    end

    // assertions
    a_timer_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        (!wr_timer && do_inc && timer_count_r == 8'hFF) |=> timer_count_r == 8'h00)
        else $error("timer did not wrap");
    a_pin_drive: assert property (@(posedge pclk) disable iff (!presetn)
        cmp_out_pin_oe |-> (cmp_on && !cmp_ctl_r[TPC_CMP_DRIVE_N]))
        else $error("pin driven while disabled");
    a_off_no_effect: assert property (@(posedge pclk) disable iff (!presetn)
        !cmp_on |-> (!cmp_wake_en && !cmp_out_pin_oe && !neg_ref_sel_o))
        else $error("comparator bits act while off");
    a_instr_src: assert property (@(posedge pclk) disable iff (!presetn)
        !option_r[TPC_OPT_SRC] |-> src_sel == TPC_SRC_INSTR)
        else $error("source not instruction");
    a_samp_phase: assert property (@(posedge pclk) disable iff (!presetn)
        !sample_now |=> $stable(samp_r))
        else $error("sample outside phase");
    a_scaler_excl: assert property (@(posedge pclk) disable iff (!presetn)
        assign_wdt |-> (wdt_tick == scal_tap))
        else $error("scaler not with watchdog");
    a_clr_timer: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_timer && !assign_wdt) |-> scal_clr)
        else $error("timer write kept scaler");
    a_clr_wdt: assert property (@(posedge pclk) disable iff (!presetn)
        (wdt_clear && assign_wdt) |=> !scal_tap)
        else $error("watchdog clear kept scaler");
    a_result_ro: assert property (@(posedge pclk) disable iff (!presetn)
        cmp_on && cmp_ctl_r[TPC_CMP_POL] |-> prdata[7] == cmp_s || paddr != TPC_OFS_CMP)
        else $error("result mismatch");
    a_rise_once: assert property (@(posedge pclk) disable iff (!presetn)
        samp_rise |=> !samp_rise)
        else $error("sampled rise held two cycles");
    a_scal_clr_tap: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_timer && !assign_wdt) |=> !scal_tap)
        else $error("timer write left scaler tap set");
    a_off_result: assert property (@(posedge pclk) disable iff (!presetn)
        !cmp_on |-> !cmp_out_pin_o)
        else $error("result shown while off");
    a_pol_pass: assert property (@(posedge pclk) disable iff (!presetn)
        (cmp_on && cmp_ctl_r[TPC_CMP_POL]) |-> cmp_out_pin_o == cmp_s)
        else $error("result not passed");
    a_pol_inv: assert property (@(posedge pclk) disable iff (!presetn)
        (cmp_on && !cmp_ctl_r[TPC_CMP_POL]) |-> cmp_out_pin_o == !cmp_s)
        else $error("result not inverted");
    a_pin_src: assert property (@(posedge pclk) disable iff (!presetn)
        (option_r[TPC_OPT_SRC] && cmp_on && cmp_ctl_r[TPC_CMP_TSRC]
        && cmp_ctl_r[TPC_CMP_DRIVE_N]) |-> src_sel == TPC_SRC_PIN)
        else $error("pin source not chosen");
    a_cmp_src: assert property (@(posedge pclk) disable iff (!presetn)
        (option_r[TPC_OPT_SRC] && cmp_on && !cmp_ctl_r[TPC_CMP_TSRC])
        |-> src_sel == TPC_SRC_CMP)
        else $error("comparator source not chosen");
    a_wdt_unscaled: assert property (@(posedge pclk) disable iff (!presetn)
        !assign_wdt |-> wdt_tick == phase_end)
        else $error("watchdog scaled while timer owns scaler");
endmodule : tpc_timer_ctl
`default_nettype wire
